// ===== rtl/rstm_defines.svh
// Purpose : Offsets, field positions, reset values and timing counts of the trace monitor.
// Assumes : Included by bare name from the package file and the bench.
// Notes   : Register offsets are byte addresses on the AHB-Lite bus.
`ifndef RSTM_DEFINES_SVH
`define RSTM_DEFINES_SVH

// ----------------------------------------------------------------------
// Register map
// ----------------------------------------------------------------------
`define RSTM_OFS_CTRL     12'h000
`define RSTM_OFS_AIS_EN   12'h004
`define RSTM_OFS_STATUS   12'h008
`define RSTM_BASE_EXP     2'h1
`define RSTM_BASE_ACC     2'h2
`define RSTM_BASE_PRV     2'h3

// ----------------------------------------------------------------------
// Control fields
// ----------------------------------------------------------------------
`define RSTM_CTRL_LEN_LO  0
`define RSTM_CTRL_LEN_HI  1
`define RSTM_CTRL_MSB     2
`define RSTM_CTRL_FIVE    3
`define RSTM_CTRL_CRC     4
`define RSTM_CTRL_ACC_IE  5
`define RSTM_CTRL_MIS_IE  6
`define RSTM_CTRL_PTRP    7
`define RSTM_CTRL_RST     8'h05
`define RSTM_AIS_EN_RST   8'h00

// ----------------------------------------------------------------------
// Status fields
// ----------------------------------------------------------------------
`define RSTM_ST_MIS       0
`define RSTM_ST_UNST      1
`define RSTM_ST_ACC       2
`define RSTM_ST_CRC       3
`define RSTM_ST_UNSPEC    4
`define RSTM_ST_MISEV     5
`define RSTM_ST_LOCK      6

// ----------------------------------------------------------------------
// Trace constants and timing
// ----------------------------------------------------------------------
`define RSTM_LF_CHAR      8'h0A
`define RSTM_UNSPEC_CHAR  8'h01
`define RSTM_UNST_LIMIT   4'h8
`define RSTM_CRC_POLY     7'h09
`define RSTM_CLK_MHZ      250
`define RSTM_AIS_LIM_NS   125000
`define RSTM_AIS_LIM_CYC  ((`RSTM_AIS_LIM_NS * `RSTM_CLK_MHZ) / 1000)

`endif

// ===== rtl/rstm_pkg.sv
// Purpose : Types shared by the trace monitor.
// Assumes : rstm_defines.svh is on the include path.
// Notes   : Constants live in the header as macros.
`include "rstm_defines.svh"

package rstm_pkg;

   typedef enum logic [1:0] {
      RSTM_LEN_1  = 2'h0,
      RSTM_LEN_16 = 2'h1,
      RSTM_LEN_64 = 2'h2
   } rstm_len_t;

   typedef logic [7:0] rstm_byte_t;

endpackage : rstm_pkg

// ===== rtl/rstm_top.sv
// Purpose : Receive section trace monitor with downstream path AIS control.
// Assumes : Trace bytes and defect levels come from logic on hclk.
// Notes   : Registers are reached over AHB-Lite with zero wait states.
//
// Notes on behaviour
// - Sixteen-byte frame: first byte is one then seven CRC bits, MSB first.
// - Other fifteen bytes start with zero and carry one character.
// - A received single byte of 00000001 means the trace is unspecified.
// - Software selects expected message length of 1, 16 or 64 bytes.
// - Start of message is found by line feed or leading one bit.
// - Accept a message after three or five identical consecutive receptions.
// - Raise an interrupt whenever a new message is accepted.
// - On acceptance compare with expected message and flag any difference.
// - Instability counter increments for each byte differing from the same byte of the previous message.
// - Declare invalid trace when the instability counter reaches eight.
// - Instability counter clears to zero when a message is accepted.
// - Storage is a 128x8 two-segment store and a 64x8 expected store.
// - On acceptance the accepted and previous segments swap roles.
// - AIS may be caused by eight line and trace defect conditions.
// - Path AIS starts within 125 us of a triggering defect.
// - During AIS pointer bytes and payload are all ones downstream.
// - Path AIS ends within 125 us of its cause clearing.
// - With pointer processing, removal sends a pointer with new data flag.
// - Each condition has its own enable driving the insertion enable.
`timescale 1ns/1ns

module rstm_top #(
   parameter int ADDR_W      = 12,
   parameter int AIS_MAX_CYC = `RSTM_AIS_LIM_CYC
) (
   input  wire logic              hclk,
   input  wire logic              hresetn,
   input  wire logic              hsel,
   input  wire logic [ADDR_W-1:0] haddr,
   input  wire logic [1:0]        htrans,
   input  wire logic              hwrite,
   input  wire logic [2:0]        hsize,
   input  wire logic [31:0]       hwdata,
   input  wire logic              hready,
   output logic                   hreadyout,
   output logic                   hresp,
   output logic [31:0]            hrdata,
   input  wire rstm_pkg::rstm_byte_t trace_byte,
   input  wire logic              trace_byte_en,
   input  wire logic              line_ais,
   input  wire logic              loss_of_signal,
   input  wire logic              loss_of_frame,
   input  wire logic              pointer_loss_condition,
   input  wire logic              signal_degrade,
   input  wire logic              signal_fail,
   output logic                   trace_mismatch_flag,
   output logic                   trace_invalid,
   output logic                   trace_irq,
   output logic                   ais_insert,
   output logic                   ais_new_data_flag
);
   import rstm_pkg::*;

   // ----------------------------------------------------------------------
   // Helper functions
   // ----------------------------------------------------------------------
   function automatic logic [6:0] crc7_byte(input logic [6:0] crc, input logic [7:0] data);
      logic [6:0] c;
      logic       fb;
      c = crc;
      for (int i = 7; i >= 0; i--) begin
         fb = data[i] ^ c[6];
         c  = {c[5:0], 1'b0} ^ (fb ? `RSTM_CRC_POLY : 7'h00);
      end
      return c;
   endfunction : crc7_byte

   function automatic logic [5:0] last_index(input logic [1:0] sel);
      if (sel == RSTM_LEN_1) begin
         return 6'h00;
      end else if (sel == RSTM_LEN_16) begin
         return 6'h0F;
      end
      return 6'h3F;
   endfunction : last_index

   // ----------------------------------------------------------------------
   // State
   // ----------------------------------------------------------------------
   logic [7:0]  ctrl_ff, ais_en_ff;
   rstm_byte_t  store_ff [128];
   rstm_byte_t  exp_ff [64];
   logic        seg_ff, lock_ff, have_prev_ff, have_acc_ff, just_acc_ff;
   logic [5:0]  idx_ff;
   logic        ref_diff_ff, acc_diff_ff, exp_diff_ff;
   logic [2:0]  consec_ff;
   logic [6:0]  crc_ff, crc_prev_ff;
   logic        crc_valid_ff, crc_err_ff;
   logic [3:0]  unst_cnt_ff;
   logic        unst_ff, mis_ff, unspec_ff, acc_st_ff, mis_st_ff;
   logic        ais_ff, ndf_ff, irq_ff;
   logic        wr_ff, hready_ff;
   logic [ADDR_W-1:0] addr_ff;
   logic [31:0] hrdata_ff;

   // ----------------------------------------------------------------------
   // Message alignment and comparison
   // ----------------------------------------------------------------------
   wire logic [1:0] len_sel  = ctrl_ff[`RSTM_CTRL_LEN_HI:`RSTM_CTRL_LEN_LO];
   wire logic       msb_mode = ctrl_ff[`RSTM_CTRL_MSB];
   wire logic       len_one  = (len_sel == RSTM_LEN_1);
   wire logic       len_16   = (len_sel == RSTM_LEN_16);
   wire logic [5:0] last_idx = last_index(len_sel);
   wire logic [2:0] need     = ctrl_ff[`RSTM_CTRL_FIVE] ? 3'h5 : 3'h3;
   wire logic       lf_seen  = trace_byte_en & ~lock_ff & ~msb_mode & ~len_one
                               & (trace_byte == `RSTM_LF_CHAR);
   wire logic       msb_hit  = ~lock_ff & msb_mode & trace_byte[7];
   wire logic       take     = trace_byte_en & (lock_ff | len_one | msb_hit);
   wire logic [5:0] cur_idx  = (lock_ff & ~len_one) ? idx_ff : 6'h00;
   wire logic       first    = (cur_idx == 6'h00);
   wire logic       at_end   = (cur_idx == last_idx);
   // The leading bit marks the first byte only; any other pattern breaks alignment.
   wire logic       frm_err  = take & msb_mode & len_16
                               & (first ? ~trace_byte[7] : trace_byte[7]);
   wire logic       use_b    = take & ~frm_err;
   wire rstm_byte_t prv_b    = store_ff[{~seg_ff, cur_idx}];
   wire rstm_byte_t acc_b    = store_ff[{seg_ff, cur_idx}];
   wire rstm_byte_t exp_b    = exp_ff[cur_idx];
   // Right after a swap the byte last received sits in the accepted segment.
   wire rstm_byte_t ref_b    = just_acc_ff ? acc_b : prv_b;
   wire logic       ref_ne   = (trace_byte != ref_b);
   wire logic       ref_d_n  = (~first & ref_diff_ff) | ref_ne;
   wire logic       acc_d_n  = (~first & acc_diff_ff) | (trace_byte != acc_b);
   wire logic       exp_d_n  = (~first & exp_diff_ff) | (trace_byte != exp_b);
   wire logic       msg_end  = use_b & at_end;
   wire logic       same     = have_prev_ff & ~ref_d_n;
   wire logic [2:0] consec_n = ~same ? 3'h1 : ((consec_ff >= need) ? need : consec_ff + 3'h1);
   wire logic       accept   = msg_end & (consec_n == need)
                               & (~have_acc_ff | acc_d_n);
   wire logic       unst_inc = use_b & have_prev_ff & ref_ne;
   wire logic [3:0] unst_n   = accept ? 4'h0
                               : ((unst_inc & (unst_cnt_ff != 4'hF)) ? unst_cnt_ff + 4'h1
                                                                     : unst_cnt_ff);
   wire rstm_byte_t crc_in   = first ? {trace_byte[7], 7'h00} : trace_byte;
   wire logic [6:0] crc_n    = crc7_byte(first ? 7'h00 : crc_ff, crc_in);
   wire logic       crc_bad  = use_b & first & len_16 & msb_mode & crc_valid_ff
                               & ctrl_ff[`RSTM_CTRL_CRC] & (trace_byte[6:0] != crc_prev_ff);

   // ----------------------------------------------------------------------
   // Bus decode
   // ----------------------------------------------------------------------
   wire logic       addr_ph  = hsel & htrans[1] & hready;
   wire logic       wr_do    = wr_ff & hready_ff;
   wire logic [1:0] a_bank   = addr_ff[9:8];
   wire logic [5:0] a_idx    = addr_ff[7:2];
   wire logic       a_top    = (addr_ff[ADDR_W-1:10] == '0);
   wire logic       w_ctrl   = wr_do & (addr_ff == `RSTM_OFS_CTRL);
   wire logic       w_aisen  = wr_do & (addr_ff == `RSTM_OFS_AIS_EN);
   wire logic       w_stat   = wr_do & (addr_ff == `RSTM_OFS_STATUS);
   wire logic       w_exp    = wr_do & a_top & (a_bank == `RSTM_BASE_EXP);
   wire logic [1:0] r_bank   = haddr[9:8];
   wire logic [5:0] r_idx    = haddr[7:2];
   wire logic       r_top    = (haddr[ADDR_W-1:10] == '0);
   wire logic [7:0] status_v = {1'b0, lock_ff, mis_st_ff, unspec_ff, crc_err_ff, acc_st_ff,
                                unst_ff, mis_ff};
   logic [31:0] rd_v;
   assign rd_v = (haddr == `RSTM_OFS_CTRL)   ? {24'h000000, ctrl_ff}
               : (haddr == `RSTM_OFS_AIS_EN) ? {24'h000000, ais_en_ff}
               : (haddr == `RSTM_OFS_STATUS) ? {20'h00000, unst_cnt_ff, status_v}
               : (r_top & r_bank == `RSTM_BASE_EXP) ? {24'h000000, exp_ff[r_idx]}
               : (r_top & r_bank == `RSTM_BASE_ACC) ? {24'h000000, store_ff[{seg_ff, r_idx}]}
               : (r_top & r_bank == `RSTM_BASE_PRV) ? {24'h000000, store_ff[{~seg_ff, r_idx}]}
               : 32'h00000000;

   // ----------------------------------------------------------------------
   // Defect gathering
   // ----------------------------------------------------------------------
   wire logic [7:0] cond  = {unst_ff, mis_ff, signal_fail, signal_degrade,
                             pointer_loss_condition, loss_of_frame, loss_of_signal,
                             line_ais};
   wire logic       ais_n = |(cond & ais_en_ff);
   wire logic       irq_n = (acc_st_ff & ctrl_ff[`RSTM_CTRL_ACC_IE])
                          | (mis_st_ff & ctrl_ff[`RSTM_CTRL_MIS_IE]);

   // ----------------------------------------------------------------------
   // AHB-Lite slave
   // ----------------------------------------------------------------------
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         wr_ff     <= 1'b0;
         hready_ff <= 1'b1;
         addr_ff   <= '0;
         hrdata_ff <= 32'h00000000;
      end else begin
         wr_ff     <= addr_ph & hwrite;
         hready_ff <= 1'b1;
         addr_ff   <= addr_ph ? haddr : addr_ff;
         hrdata_ff <= (addr_ph & ~hwrite) ? rd_v : hrdata_ff;
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         ctrl_ff   <= `RSTM_CTRL_RST;
         ais_en_ff <= `RSTM_AIS_EN_RST;
      end else begin
         ctrl_ff   <= w_ctrl ? hwdata[7:0] : ctrl_ff;
         ais_en_ff <= w_aisen ? hwdata[7:0] : ais_en_ff;
      end
   end

   always_ff @(posedge hclk) begin
      if (w_exp) begin
         exp_ff[a_idx] <= hwdata[7:0];
      end
   end

   // ----------------------------------------------------------------------
   // Trace store
   // ----------------------------------------------------------------------
   always_ff @(posedge hclk) begin
      if (use_b) begin
         store_ff[{~seg_ff, cur_idx}] <= trace_byte;
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         seg_ff       <= 1'b0;
         lock_ff      <= 1'b0;
         idx_ff       <= 6'h00;
         have_prev_ff <= 1'b0;
         have_acc_ff  <= 1'b0;
         just_acc_ff  <= 1'b0;
         consec_ff    <= 3'h0;
      end else if (frm_err) begin
         lock_ff      <= 1'b0;
         have_prev_ff <= 1'b0;
         consec_ff    <= 3'h0;
      end else begin
         seg_ff  <= accept ? ~seg_ff : seg_ff;
         lock_ff <= lock_ff | lf_seen | msb_hit;
         if (lf_seen) begin
            idx_ff <= 6'h00;
         end else if (use_b) begin
            idx_ff <= at_end ? 6'h00 : cur_idx + 6'h01;
         end
         if (msg_end) begin
            have_prev_ff <= 1'b1;
            consec_ff    <= consec_n;
            just_acc_ff  <= accept;
         end
         have_acc_ff <= have_acc_ff | accept;
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         ref_diff_ff <= 1'b0;
         acc_diff_ff <= 1'b0;
         exp_diff_ff <= 1'b0;
         crc_ff      <= 7'h00;
         crc_prev_ff <= 7'h00;
         crc_valid_ff <= 1'b0;
      end else if (use_b) begin
         ref_diff_ff <= ref_d_n;
         acc_diff_ff <= acc_d_n;
         exp_diff_ff <= exp_d_n;
         crc_ff      <= crc_n;
         crc_prev_ff <= at_end ? crc_n : crc_prev_ff;
         crc_valid_ff <= crc_valid_ff | at_end;
      end
   end

   // ----------------------------------------------------------------------
   // Status flags; a hardware set wins over a software clear.
   // ----------------------------------------------------------------------
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         unst_cnt_ff <= 4'h0;
         unst_ff     <= 1'b0;
         mis_ff      <= 1'b0;
         unspec_ff   <= 1'b0;
         acc_st_ff   <= 1'b0;
         mis_st_ff   <= 1'b0;
         crc_err_ff  <= 1'b0;
      end else begin
         unst_cnt_ff <= unst_n;
         unst_ff     <= (unst_n >= `RSTM_UNST_LIMIT);
         mis_ff      <= accept ? exp_d_n : mis_ff;
         unspec_ff   <= accept ? (len_one & (trace_byte == `RSTM_UNSPEC_CHAR)) : unspec_ff;
         acc_st_ff   <= accept | (acc_st_ff & ~(w_stat & hwdata[`RSTM_ST_ACC]));
         mis_st_ff   <= (accept & exp_d_n) | (mis_st_ff & ~(w_stat & hwdata[`RSTM_ST_MISEV]));
         crc_err_ff  <= crc_bad | (crc_err_ff & ~(w_stat & hwdata[`RSTM_ST_CRC]));
      end
   end

   // ----------------------------------------------------------------------
   // Outputs
   // ----------------------------------------------------------------------
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         ais_ff <= 1'b0;
         ndf_ff <= 1'b0;
         irq_ff <= 1'b0;
      end else begin
         ais_ff <= ais_n;
         ndf_ff <= ais_ff & ~ais_n & ctrl_ff[`RSTM_CTRL_PTRP];
         irq_ff <= irq_n;
      end
   end

   assign hreadyout           = hready_ff;
   assign hresp               = 1'b0;
   assign hrdata              = hrdata_ff;
   assign trace_mismatch_flag = mis_ff;
   assign trace_invalid       = unst_ff;
   assign trace_irq           = irq_ff;
   assign ais_insert          = ais_ff;
   assign ais_new_data_flag   = ndf_ff;

   // ----------------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------------
   logic [31:0] ais_wait_ff;
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         ais_wait_ff <= 32'h00000000;
      end else begin
         ais_wait_ff <= (ais_n != ais_ff) ? ais_wait_ff + 32'h00000001 : 32'h00000000;
      end
   end

   default clocking cb @(posedge hclk); endclocking
   default disable iff (!hresetn);

   accept_count_a: assert property (accept |-> consec_n == need)
      else $error("accept without enough repeats");
   accept_irq_a: assert property (accept & ctrl_ff[`RSTM_CTRL_ACC_IE] |-> ##2 trace_irq)
      else $error("accept gave no interrupt");
   mis_update_a: assert property (accept |=> trace_mismatch_flag == $past(exp_d_n))
      else $error("mismatch flag wrong after accept");
   unst_step_a: assert property (unst_inc & ~accept & unst_cnt_ff < 4'hF
                                 |=> unst_cnt_ff == $past(unst_cnt_ff) + 4'h1)
      else $error("instability count did not step");
   unst_decl_a: assert property ($rose(unst_cnt_ff == `RSTM_UNST_LIMIT) |-> trace_invalid)
      else $error("invalid trace not declared at eight");
   unst_clear_a: assert property (accept |=> unst_cnt_ff == 4'h0 && !trace_invalid)
      else $error("instability count not cleared");
   seg_swap_a: assert property (accept |=> seg_ff != $past(seg_ff))
      else $error("segments did not swap");
   ais_bound_a: assert property (ais_wait_ff < AIS_MAX_CYC)
      else $error("AIS change too late");
   ais_follow_a: assert property (ais_n |=> ais_insert)
      else $error("enabled condition gave no AIS");
   ndf_pulse_a: assert property ($fell(ais_insert) & ctrl_ff[`RSTM_CTRL_PTRP]
                                 |-> ais_new_data_flag ##1 !ais_new_data_flag || ais_insert)
      else $error("new data flag not one pulse on removal");
   start_bit_a: assert property (use_b & first & msb_mode & len_16 |-> trace_byte[7])
      else $error("message start without leading one");

   // ----------------------------------------------------------------------
   // Flag checks
   // ----------------------------------------------------------------------
   // The sticky accept flag feeds the interrupt, so it must follow every acceptance.
   acc_sticky_a: assert property (accept |=> acc_st_ff)
      else $error("accept flag not set");
   unspec_flag_a: assert property (accept & len_one & (trace_byte == `RSTM_UNSPEC_CHAR)
                                   |=> unspec_ff)
      else $error("unspecified trace not flagged");
   // Insertion must also drop once no enabled condition remains.
   ais_drop_a: assert property (!ais_n |=> !ais_insert)
      else $error("AIS held without enabled condition");

endmodule : rstm_top

// ===== bench/rstm_trace_src.sv
// Purpose : Upstream section trace source that repeats one message on request.
// Assumes : Requests come from the bench on the rising edge of hclk.
// Notes   : Between bytes the data lines show the inverse of the last byte.
`timescale 1ns/1ns

module rstm_trace_src (
   input  wire logic                 hclk,
   input  wire logic                 go,
   input  wire logic [3:0]           nrep,
   input  wire logic [6:0]           len,
   input  wire rstm_pkg::rstm_byte_t msg [16],
   output rstm_pkg::rstm_byte_t      trace_byte,
   output logic                      trace_byte_en,
   output logic                      busy
);
   import rstm_pkg::*;
   initial begin
      trace_byte    = 8'h00;
      trace_byte_en = 1'b0;
      busy          = 1'b0;
   end
   // Each byte goes out as given in msg; the source adds no leading bit.
   always begin
      @(posedge hclk);
      if (go) begin
         busy <= 1'b1;
         for (int r = 0; r < nrep; r++) begin
            for (int i = 0; i < len; i++) begin
               trace_byte    <= msg[i];
               trace_byte_en <= 1'b1;
               @(posedge hclk);
               trace_byte_en <= 1'b0;
               trace_byte    <= ~msg[i];
               @(posedge hclk);
            end
         end
         busy <= 1'b0;
      end
   end
endmodule : rstm_trace_src

// ===== bench/test_rstm_top.sv
// Purpose : Self-checking bench for the trace monitor and AIS control.
// Assumes : Zero wait state slave; trace bytes come from rstm_trace_src.
// Notes   : Messages are sixteen bytes unless a scenario says otherwise.
`include "rstm_defines.svh"
`timescale 1ns/1ns

module test_rstm_top;
   import rstm_pkg::*;
   logic        hclk = 0, hresetn = 0, hsel = 0, hwrite = 0, go = 0;
   logic [11:0] haddr = 0;
   logic [1:0]  htrans = 0;
   logic [2:0]  hsize = 3'h2;
   logic [31:0] hwdata = 0, hrdata;
   logic [5:0]  dfx = 0;
   logic [3:0]  nrep = 0;
   logic [6:0]  len = 7'h10;
   rstm_byte_t  msg [16], m1 [16], m2 [16], tb_byte;
   logic        hreadyout, hresp, tb_en, busy, mis, inv, irq, ais, ndf;
   int          n_errors = 0, n_tests = 0;

   rstm_top i_rstm_top (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
      .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .trace_byte(tb_byte),
      .trace_byte_en(tb_en), .line_ais(dfx[0]), .loss_of_signal(dfx[1]),
      .loss_of_frame(dfx[2]), .pointer_loss_condition(dfx[3]), .signal_degrade(dfx[4]),
      .signal_fail(dfx[5]), .trace_mismatch_flag(mis), .trace_invalid(inv),
      .trace_irq(irq), .ais_insert(ais), .ais_new_data_flag(ndf));
   rstm_trace_src i_rstm_trace_src (.hclk(hclk), .go(go), .nrep(nrep), .len(len),
      .msg(msg), .trace_byte(tb_byte), .trace_byte_en(tb_en), .busy(busy));

   // ----------------------------------------------------------------------
   // Bus cycles, comparison and trace requests
   // ----------------------------------------------------------------------
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      n_tests++;
      if (seen !== exp) begin
         n_errors++;
         $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask : chk
   task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] wd,
                      output logic [31:0] rd);
      hsel <= 1'b1; htrans <= 2'h2; haddr <= a; hwrite <= w;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      hsel <= 1'b0; htrans <= 2'h0; hwdata <= wd;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      rd = hrdata;
   endtask : bus
   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      logic [31:0] v;
      bus(1'b1, a, d, v);
   endtask : wr
   task automatic rdc(input logic [11:0] a, input logic [31:0] m, input logic [31:0] e);
      logic [31:0] v;
      bus(1'b0, a, 32'h0, v);
      chk(v & m, e);
   endtask : rdc
   task automatic send(input logic [3:0] n);
      nrep <= n; go <= 1'b1;
      @(posedge hclk);
      go <= 1'b0;
      do @(posedge hclk); while (busy);
      repeat (3) @(posedge hclk);
   endtask : send
   task automatic ais_chk(input logic [7:0] en, input logic e);
      wr(`RSTM_OFS_AIS_EN, {24'h0, en});
      repeat (3) @(posedge hclk);
      chk({31'h0, ais}, {31'h0, e});
   endtask : ais_chk
   task automatic stop_test;
      if (n_errors == 0 && n_tests > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask : stop_test

   initial begin
      forever #2 hclk = ~hclk;
   end
   initial begin
      repeat (30000) @(posedge hclk);
      n_errors++;
      stop_test;
   end

   initial begin
      int n;
      for (int i = 0; i < 16; i++) m1[i] = (i == 0) ? 8'h80 : 8'h41 + i;
      m2 = m1; m2[5] = 8'h7A; msg = m1;
      repeat (2) @(posedge hclk);
      hresetn <= 1'b1;
      @(posedge hclk);
      rdc(`RSTM_OFS_CTRL, 32'hFF, {24'h0, `RSTM_CTRL_RST});
      rdc(`RSTM_OFS_AIS_EN, 32'hFF, {24'h0, `RSTM_AIS_EN_RST});
      rdc(12'h00C, 32'hFFFFFFFF, 32'h0);
      for (int i = 0; i < 16; i++) wr(12'h100 + 4 * i, {24'h0, m1[i]});
      wr(`RSTM_OFS_CTRL, 32'hA5);
      send(2);
      rdc(`RSTM_OFS_STATUS, 32'h04, 32'h0);
      send(1);
      rdc(`RSTM_OFS_STATUS, 32'hF07, 32'h004);
      chk({31'h0, irq}, 32'h1);
      for (int i = 0; i < 6; i++) begin
         dfx <= 6'h1 << i;
         ais_chk(~(8'h1 << i), 1'b0);
         ais_chk(8'h1 << i, 1'b1);
         dfx <= 6'h0; n = 0;
         repeat (3) begin
            @(posedge hclk); #1;
            if (ndf === 1'b1) n++;
         end
         chk({31'h0, ais}, 32'h0);
         chk(n, 1);
      end
      wr(`RSTM_OFS_STATUS, 32'h04);
      repeat (2) @(posedge hclk);
      chk({31'h0, irq}, 32'h0);
      wr(`RSTM_OFS_CTRL, 32'hAD); msg = m2;
      send(4);
      rdc(`RSTM_OFS_STATUS, 32'h04, 32'h0);
      send(1);
      rdc(`RSTM_OFS_STATUS, 32'hF07, 32'h005);
      chk({30'h0, irq, mis}, 32'h3);
      ais_chk(8'h40, 1'b1);
      wr(`RSTM_OFS_CTRL, 32'hA5);
      for (int k = 0; k < 8; k++) begin
         msg = k[0] ? m2 : m1;
         send(1);
      end
      rdc(`RSTM_OFS_STATUS, 32'hF02, 32'h802);
      chk({31'h0, inv}, 32'h1);
      ais_chk(8'h80, 1'b1);
      msg = m1;
      send(3);
      rdc(`RSTM_OFS_STATUS, 32'hF03, 32'h0);
      for (int i = 0; i < 16; i++) begin
         rdc(12'h200 + 4 * i, 32'hFF, {24'h0, m1[i]});
         rdc(12'h300 + 4 * i, 32'hFF, {24'h0, m2[i]});
      end
      wr(`RSTM_OFS_CTRL, 32'h24); len <= 7'h1; msg[0] = 8'h01;
      send(5);
      rdc(`RSTM_OFS_STATUS, 32'h11, 32'h11);
      stop_test;
   end
endmodule : test_rstm_top
